// File: rtl/wdpll_ctrl.v
// watchdog, divider programming, strap capture and bus clock stop control
// Function
// [R1] bit 7 chooses power-down input or reset output
// [R2] bit 6 chooses revert frequency after expiry
// [R3] host writes zero to test bit 5
// [R4] expiry flag set on timeout, cleared with interval
// [R5] low nibble: off or n seconds interval
// [R6] expiry with pin as output pulses reset
// [R7] rising write of bit 7 makes one pulse
// [R8] seven-bit feedback divider value for PLL
// [R9] six-bit reference divider value for PLL
// [R10] skew bit shifts one cpu output
// [R11] source bit picks programmed or ROM dividers
// [R12] derived clocks keep ratio to cpu clock
// [R13] host keeps dividers in legal range
// [R14] cpu frequency is constant times N over M
// [R15] straps captured before any clock enabled
// [R16] clocks held off until PLL lock
// [R17] spread only on cpu PLL outputs
// [R18] center/down spread, two amounts, 33 kHz
// [R19] halt sampled, stops at next falling edge
// [R20] 66 MHz link outputs ignore halt
// [R21] per-output free-running enable, default off
// [R22] keep last two software frequency settings
`include "wdpll_defs.vh"

module wdpll_ctrl #(
  parameter WD_TICK_CYC    = `WDPLL_WD_TICK_CYC,   // cycles per watchdog second
  parameter RST_PULSE_CYC  = `WDPLL_RST_PULSE_CYC, // reset pulse length
  parameter TEST_PULSE_CYC = `WDPLL_TEST_PULSE_CYC // one period of latched frequency
) (
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  input  wire       i_reg_wr,                    // byte write strobe
  input  wire       i_reg_rd,                    // byte read strobe
  input  wire [7:0] i_reg_addr,                  // register offset
  input  wire [7:0] i_reg_wdata,                 // write data
  output reg  [7:0] o_reg_rdata,                 // read data
  input  wire       i_shared_pin_in,             // shared pin level
  output wire       o_shared_pin_out,            // shared pin drive value
  output wire       o_shared_pin_oe,             // shared pin drive enable
  output wire       o_system_reset_out_n,        // reset request, active low
  output wire       o_power_down,                // power-down request
  input  wire [3:0] i_frequency_strap_select,    // strap pins
  input  wire       i_pll_lock,                  // PLL lock from analog
  input  wire       i_ss_center,                 // spread mode: 1 center
  input  wire       i_ss_amount_hi,              // spread amount: 1 = 1.0 %
  input  wire       i_bus_clock_halt_n,          // bus clock stop, active low
  input  wire [5:0] i_free_run_en,               // per bus output free-running
  input  wire [2:0] i_link_66_sel,               // link output runs at 66 MHz
  output reg  [3:0] o_strap_fs,                  // latched strap value
  output wire       o_clk_out_en,                // clock outputs allowed
  output reg  [6:0] o_feedback_divider_value,    // divider N to PLL
  output reg  [5:0] o_reference_divider_value,   // divider M to PLL
  output reg        o_use_prog_div,              // 1 programmed, 0 ROM
  output reg        o_cpu_skew,                  // skew select
  output reg        o_cpu_pulse_t,               // test pulse true leg
  output reg        o_cpu_pulse_c,               // test pulse complement leg
  output reg        o_ss_enable,                 // spread on cpu PLL only
  output reg        o_ss_center,                 // spread mode to PLL
  output reg        o_ss_amount_hi,              // spread amount to PLL
  output reg        o_ss_dir,                    // modulation ramp direction
  output reg  [5:0] o_bus_clock_outputs,         // stoppable bus clocks
  output reg        o_free_running_bus_clock,    // not stopped by halt, only by o_clk_out_en
  output reg  [2:0] o_bus_or_link_clock          // bus or link clocks
);

  // register decode shared by write and read paths
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // pin synchronisers: first stage read only by the second
  reg [1:0] pin_sync_ff;
  reg [1:0] lock_sync_ff;
  reg [1:0] halt_sync_ff;
  reg [1:0] ssc_sync_ff;
  reg [1:0] ssa_sync_ff;
  reg [3:0] strap_s1_ff;
  reg [3:0] strap_s2_ff;
  reg [8:0] sel_s1_ff;     // {link 66 select, free-run enables}, stage 1
  reg [8:0] sel_s2_ff;     // same selects, safe to read

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_sync_ff  <= 2'h3;
      lock_sync_ff <= 2'h0;
      halt_sync_ff <= 2'h3;
      ssc_sync_ff  <= 2'h0;
      ssa_sync_ff  <= 2'h0;
      strap_s1_ff  <= 4'h0;
      strap_s2_ff  <= 4'h0;
      sel_s1_ff    <= 9'h000;                                         // [R21]
      sel_s2_ff    <= 9'h000;
    end
    else
    begin
      pin_sync_ff  <= {pin_sync_ff[0], i_shared_pin_in};
      lock_sync_ff <= {lock_sync_ff[0], i_pll_lock};
      halt_sync_ff <= {halt_sync_ff[0], i_bus_clock_halt_n};
      ssc_sync_ff  <= {ssc_sync_ff[0], i_ss_center};
      ssa_sync_ff  <= {ssa_sync_ff[0], i_ss_amount_hi};
      strap_s1_ff  <= i_frequency_strap_select;
      strap_s2_ff  <= strap_s1_ff;
      sel_s1_ff    <= {i_link_66_sel, i_free_run_en};
      sel_s2_ff    <= sel_s1_ff;
    end
  end

  // strap capture after release, once the sync chain holds real data
  reg [1:0] strap_wait_ff;  // settling count
  reg       strap_done_ff;  // straps latched

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      o_strap_fs    <= 4'h0;
    end
    else if (!strap_done_ff)
    begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      if (strap_wait_ff == 2'h2)
      begin
        o_strap_fs    <= strap_s2_ff;                                  // [R15]
        strap_done_ff <= 1'b1;
      end
    end
  end

  // outputs only after straps are in and the PLL is locked
  assign o_clk_out_en = strap_done_ff & lock_sync_ff[1];             // [R15] [R16]

  // register write decode
  wire wr_wd  = i_reg_wr & hit(i_reg_addr, `WDPLL_OFS_WDOG);
  wire wr_fb  = i_reg_wr & hit(i_reg_addr, `WDPLL_OFS_FBDIV);
  wire wr_rf  = i_reg_wr & hit(i_reg_addr, `WDPLL_OFS_REFDIV);

  reg  [7:0]  wd_ctl_ff;       // watchdog control, flag bit kept apart
  reg         flag_ff;         // expiry flag
  reg  [7:0]  fb_reg_ff;       // feedback divider register
  reg  [7:0]  rf_reg_ff;       // reference divider register
  reg  [6:0]  prev_n_ff;       // older software setting
  reg  [5:0]  prev_m_ff;
  reg  [6:0]  cur_n_ff;        // newest software setting
  reg  [5:0]  cur_m_ff;
  reg  [26:0] tick_cnt_ff;     // one-second prescaler
  reg  [3:0]  sec_cnt_ff;      // elapsed seconds
  reg  [7:0]  rst_cnt_ff;      // reset pulse remaining

  wire [3:0]  ivl      = wd_ctl_ff[`WDPLL_WD_IVL_HI:`WDPLL_WD_IVL_LO];
  wire        pin_in_m = wd_ctl_ff[`WDPLL_WD_PINMODE];
  wire        tick     = (tick_cnt_ff == WD_TICK_CYC[26:0] - 27'h1);
  // counting stops once expired, until software clears the interval
  wire        armed    = (ivl != 4'h0) & !flag_ff;                    // [R5]
  wire        expire   = armed & tick & (sec_cnt_ff == ivl - 4'h1);   // [R5]
  wire        new_ivl0 = wr_wd & (i_reg_wdata[3:0] == 4'h0);

  // watchdog timebase: a control write restarts the count
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_ff <= 27'h0;
      sec_cnt_ff  <= 4'h0;
    end
    else if (wr_wd || !armed)
    begin
      tick_cnt_ff <= 27'h0;
      sec_cnt_ff  <= 4'h0;
    end
    else if (tick)
    begin
      tick_cnt_ff <= 27'h0;                                           // [R5]
      sec_cnt_ff  <= sec_cnt_ff + 4'h1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 27'h1;
    end
  end

  // expiry flag: a timeout in the clearing cycle still sets it
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flag_ff <= 1'b0;
    else if (expire)
      flag_ff <= 1'b1;                                                // [R4]
    else if (new_ivl0)
      flag_ff <= 1'b0;                                                // [R4]
  end

  // reset pulse on expiry, only while the pin is an output
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_cnt_ff <= 8'h0;
    else if (expire && !pin_in_m)
      rst_cnt_ff <= RST_PULSE_CYC[7:0];                               // [R6]
    else if (rst_cnt_ff != 8'h0)
      rst_cnt_ff <= rst_cnt_ff - 8'h1;
  end

  // shared pin role
  assign o_shared_pin_oe      = !pin_in_m;                            // [R1]
  assign o_shared_pin_out     = (rst_cnt_ff == 8'h0);                 // [R1]
  assign o_system_reset_out_n = pin_in_m | (rst_cnt_ff == 8'h0);      // [R6]
  assign o_power_down         = pin_in_m & !pin_sync_ff[1];           // [R1]

  // control registers and software setting history
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wd_ctl_ff <= `WDPLL_RST_WDOG;
      fb_reg_ff <= `WDPLL_RST_FBDIV;
      rf_reg_ff <= `WDPLL_RST_REFDIV;
      prev_n_ff <= 7'h00;
      prev_m_ff <= 6'h00;
      cur_n_ff  <= 7'h00;
      cur_m_ff  <= 6'h00;
    end
    else
    begin
      // test bit stored as written; host keeps it zero
      if (wr_wd)
        wd_ctl_ff <= i_reg_wdata;                                     // [R3]
      if (wr_fb)
        fb_reg_ff <= i_reg_wdata;                                     // [R8]
      // a source-on write commits one software setting
      if (wr_rf)
      begin
        rf_reg_ff <= i_reg_wdata;                                     // [R9] [R10]
        if (i_reg_wdata[`WDPLL_RF_SRC])
        begin
          prev_n_ff <= cur_n_ff;                                      // [R22]
          prev_m_ff <= cur_m_ff;
          cur_n_ff  <= fb_reg_ff[`WDPLL_FB_VAL_HI:`WDPLL_FB_VAL_LO];
          cur_m_ff  <= i_reg_wdata[`WDPLL_RF_VAL_HI:`WDPLL_RF_VAL_LO];
        end
      end
      // revert handling on every watchdog expiry, with the pin as reset output or as power-down input
      if (expire)
      begin
        if (wd_ctl_ff[`WDPLL_WD_REVERT])
        begin
          fb_reg_ff[`WDPLL_FB_VAL_HI:`WDPLL_FB_VAL_LO] <= prev_n_ff;  // [R2]
          rf_reg_ff[`WDPLL_RF_VAL_HI:`WDPLL_RF_VAL_LO] <= prev_m_ff;  // [R2]
          rf_reg_ff[`WDPLL_RF_SRC]                     <= 1'b1;
        end
        else
          rf_reg_ff[`WDPLL_RF_SRC] <= 1'b0;                           // [R2]
      end
    end
  end

  // divider values to the PLL; post dividers untouched keep all ratios,
  // so f_cpu = P * N / M for every strap selection
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_feedback_divider_value  <= 7'h00;
      o_reference_divider_value <= 6'h00;
      o_use_prog_div            <= 1'b0;
      o_cpu_skew                <= 1'b0;
    end
    else
    begin
      o_feedback_divider_value  <= fb_reg_ff[`WDPLL_FB_VAL_HI:`WDPLL_FB_VAL_LO]; // [R8] [R14]
      o_reference_divider_value <= rf_reg_ff[`WDPLL_RF_VAL_HI:`WDPLL_RF_VAL_LO]; // [R9] [R14]
      o_use_prog_div            <= rf_reg_ff[`WDPLL_RF_SRC];          // [R11] [R12]
      o_cpu_skew                <= rf_reg_ff[`WDPLL_RF_SKEW];         // [R10]
    end
  end

  // test pulse on a 0 to 1 write of the trigger bit
  reg  [7:0] pulse_cnt_ff;
  wire       pulse_go = wr_fb & i_reg_wdata[`WDPLL_FB_PULSE] & !fb_reg_ff[`WDPLL_FB_PULSE];

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pulse_cnt_ff  <= 8'h0;
      o_cpu_pulse_t <= 1'b0;
      o_cpu_pulse_c <= 1'b1;
    end
    else
    begin
      if (pulse_go)
        pulse_cnt_ff <= TEST_PULSE_CYC[7:0];                          // [R7]
      else if (pulse_cnt_ff != 8'h0)
        pulse_cnt_ff <= pulse_cnt_ff - 8'h1;
      o_cpu_pulse_t <= (pulse_cnt_ff != 8'h0);                        // [R7]
      o_cpu_pulse_c <= (pulse_cnt_ff == 8'h0);
    end
  end

  // spread modulation ramp at 33 kHz, applied to cpu PLL only;
  // the fixed reference clocks never see this control
  reg [10:0] ss_cnt_ff;

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ss_cnt_ff      <= 11'h0;
      o_ss_dir       <= 1'b0;
      o_ss_enable    <= 1'b0;
      o_ss_center    <= 1'b0;
      o_ss_amount_hi <= 1'b0;
    end
    else
    begin
      if (ss_cnt_ff == `WDPLL_SS_HALF_CYC - 1)
      begin
        ss_cnt_ff <= 11'h0;
        o_ss_dir  <= !o_ss_dir;                                       // [R18]
      end
      else
        ss_cnt_ff <= ss_cnt_ff + 11'h1;
      o_ss_enable    <= o_clk_out_en;                                 // [R17]
      o_ss_center    <= ssc_sync_ff[1];                               // [R18]
      o_ss_amount_hi <= ssa_sync_ff[1];                               // [R18]
    end
  end

  // internal bus clock: one high, two low per period
  reg [1:0] bus_ph_ff;   // bus clock phase
  reg       run_ff;      // stoppable outputs running
  wire      bus_hi = (bus_ph_ff == 2'h0);

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_ph_ff <= 2'h0;
      run_ff    <= 1'b1;
    end
    else
    begin
      bus_ph_ff <= (bus_ph_ff == `WDPLL_BUS_DIV - 1) ? 2'h0 : bus_ph_ff + 2'h1;
      // gate moves only at the high-to-low point, so highs stay whole
      if (bus_hi)
        run_ff <= halt_sync_ff[1];                                    // [R19]
    end
  end

  // bus clock outputs; 66 MHz link outputs bypass the halt gate
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bus_clock_outputs      <= 6'h00;
      o_free_running_bus_clock <= 1'b0;
      o_bus_or_link_clock      <= 3'h0;
    end
    else
    begin
      o_bus_clock_outputs      <= {6{bus_hi & o_clk_out_en}} &
                                  ({6{run_ff}} | sel_s2_ff[5:0]);     // [R19] [R21]
      o_free_running_bus_clock <= bus_hi & o_clk_out_en;
      o_bus_or_link_clock      <= {3{bus_hi & o_clk_out_en}} &
                                  ({3{run_ff}} | sel_s2_ff[8:6]);     // [R20]
    end
  end

  // registered read; unmapped offsets answer zero
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      if (hit(i_reg_addr, `WDPLL_OFS_WDOG))
        o_reg_rdata <= {wd_ctl_ff[7:5], flag_ff, wd_ctl_ff[3:0]};
      else if (hit(i_reg_addr, `WDPLL_OFS_FBDIV))
        o_reg_rdata <= fb_reg_ff;
      else if (hit(i_reg_addr, `WDPLL_OFS_REFDIV))
        o_reg_rdata <= rf_reg_ff;
      else
        o_reg_rdata <= 8'h00;
    end
  end

endmodule // wdpll_ctrl

// File: rtl/wdpll_defs.vh
// register offsets, field positions, reset values and timing counts of the watchdog/divider block
`ifndef WDPLL_DEFS_VH
`define WDPLL_DEFS_VH

// register byte offsets
`define WDPLL_OFS_WDOG       8'h07
`define WDPLL_OFS_FBDIV      8'h08
`define WDPLL_OFS_REFDIV     8'h09

// reset values
`define WDPLL_RST_WDOG       8'h00
`define WDPLL_RST_FBDIV      8'h00
`define WDPLL_RST_REFDIV     8'h00

// watchdog control fields
`define WDPLL_WD_PINMODE     7
`define WDPLL_WD_REVERT      6
`define WDPLL_WD_TEST        5
`define WDPLL_WD_FLAG        4
`define WDPLL_WD_IVL_HI      3
`define WDPLL_WD_IVL_LO      0

// feedback divider register fields
`define WDPLL_FB_PULSE       7
`define WDPLL_FB_VAL_HI      6
`define WDPLL_FB_VAL_LO      0

// reference divider register fields
`define WDPLL_RF_SKEW        7
`define WDPLL_RF_VAL_HI      6
`define WDPLL_RF_VAL_LO      1
`define WDPLL_RF_SRC         0

// timing: clock period, watchdog tick, spread rate
`define WDPLL_CLK_PERIOD_NS  10
`define WDPLL_WD_TICK_MS     1000
`define WDPLL_WD_TICK_CYC    ((`WDPLL_WD_TICK_MS * 1000000) / `WDPLL_CLK_PERIOD_NS)
`define WDPLL_SS_RATE_HZ     33000
`define WDPLL_SS_HALF_CYC    ((1000000000 / `WDPLL_CLK_PERIOD_NS) / `WDPLL_SS_RATE_HZ / 2)
`define WDPLL_RST_PULSE_CYC  16
`define WDPLL_TEST_PULSE_CYC 1
`define WDPLL_BUS_DIV        3

`endif

// File: verification/wdpll_ctrl_properties.sv
// assertion checker for the watchdog and divider control block
module wdpll_ctrl_properties #(
  parameter int RST_PULSE_CYC  = 16, // reset pulse length
  parameter int TEST_PULSE_CYC = 1   // test pulse length
) (
  input wire       i_clk_sys,
  input wire       i_rst_n,
  input wire       i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire       i_pll_lock,
  input wire       i_bus_clock_halt_n,
  input wire [5:0] i_free_run_en,
  input wire [2:0] i_link_66_sel,
  input wire       o_shared_pin_oe,
  input wire       o_system_reset_out_n,
  input wire       o_clk_out_en,
  input wire [5:0] o_reference_divider_value,
  input wire       o_use_prog_div,
  input wire       o_cpu_skew,
  input wire       o_cpu_pulse_t,
  input wire [5:0] o_bus_clock_outputs,
  input wire [2:0] o_bus_or_link_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] low_cnt_ff; // cycles of reset output low
  logic [7:0] hi_cnt_ff;  // cycles of test pulse high
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // counters restart on each new pulse so a width is seen whole
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      low_cnt_ff <= 8'h00;
      hi_cnt_ff  <= 8'h00;
    end
    else
    begin
      low_cnt_ff <= o_system_reset_out_n ? 8'h00 : low_cnt_ff + 8'h01;
      hi_cnt_ff  <= o_cpu_pulse_t ? hi_cnt_ff + 8'h01 : 8'h00;
    end
  end
  property p_pin_role;
    i_reg_wr && i_reg_addr == 8'h07 |=> o_shared_pin_oe == !$past(i_reg_wdata[7]);
  endproperty
  a_pin_role: assert property (p_pin_role)
    else $error("pin role does not follow control bit");
  property p_rst_len;
    $rose(o_system_reset_out_n) |-> low_cnt_ff == 8'(RST_PULSE_CYC);
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");
  property p_rst_src;
    !o_system_reset_out_n |-> o_shared_pin_oe;
  endproperty
  a_rst_src: assert property (p_rst_src)
    else $error("reset driven while pin is an input");
  property p_pulse_len;
    $fell(o_cpu_pulse_t) |-> hi_cnt_ff == 8'(TEST_PULSE_CYC);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("test pulse width wrong");
  property p_lock_gate;
    !i_pll_lock ##1 !i_pll_lock |=> !o_clk_out_en;
  endproperty
  a_lock_gate: assert property (p_lock_gate)
    else $error("outputs enabled without lock");
  property p_off_quiet;
    !o_clk_out_en ##1 !o_clk_out_en |-> o_bus_clock_outputs == 6'h00 && o_bus_or_link_clock == 3'h0;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("clock toggles while disabled");
  property p_halt;
    (!i_bus_clock_halt_n && i_free_run_en == 6'h00 && i_link_66_sel == 3'h0)[*8]
      |-> o_bus_clock_outputs == 6'h00 && o_bus_or_link_clock == 3'h0;
  endproperty
  a_halt: assert property (p_halt)
    else $error("bus clock runs while halted");
  property p_link_run;
    // six cycles: two for the select synchroniser, one for the output register, three for one bus period
    (o_clk_out_en && i_link_66_sel[0])[*6] |-> o_bus_or_link_clock[0]
      || $past(o_bus_or_link_clock[0]) || $past(o_bus_or_link_clock[0], 2);
  endproperty
  a_link_run: assert property (p_link_run)
    else $error("fast link clock stopped");
  property p_div_regs;
    i_reg_wr && i_reg_addr == 8'h09 |=> ##1
      {o_cpu_skew, o_reference_divider_value, o_use_prog_div} == $past(i_reg_wdata, 2);
  endproperty
  a_div_regs: assert property (p_div_regs)
    else $error("reference divider fields not passed on");
endmodule // wdpll_ctrl_properties

bind wdpll_ctrl wdpll_ctrl_properties #(
  .RST_PULSE_CYC (RST_PULSE_CYC),
  .TEST_PULSE_CYC(TEST_PULSE_CYC)
) chk_u (
  .i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_pll_lock,
  .i_bus_clock_halt_n, .i_free_run_en, .i_link_66_sel, .o_shared_pin_oe,
  .o_system_reset_out_n, .o_clk_out_en, .o_reference_divider_value,
  .o_use_prog_div, .o_cpu_skew, .o_cpu_pulse_t, .o_bus_clock_outputs,
  .o_bus_or_link_clock
);

// File: verification/wdpll_sys_model.sv
// system-side model: shared pin wiring and a PLL that locks late
module wdpll_sys_model #(
  parameter int LOCK_DLY = 20 // cycles from reset release to lock
) (
  input  wire logic i_clk_sys, // system clock
  input  wire logic i_rst_n,   // reset, active low
  input  wire logic i_pin_out, // device drive value
  input  wire logic i_pin_oe,  // device drives the pin
  input  wire logic i_pd_n,    // board power-down request
  output logic      o_pin,     // resolved pin level
  output logic      o_lock     // PLL lock indication
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] lock_cnt_ff; // cycles since reset release
  // board drives the pin only once the device lets go of it
  assign o_pin = i_pin_oe ? i_pin_out : i_pd_n;
  // lock comes late so output gating is really exercised
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lock_cnt_ff <= 8'h00;
    else if (lock_cnt_ff != 8'(LOCK_DLY))
      lock_cnt_ff <= lock_cnt_ff + 8'h01;
  end
  assign o_lock = (lock_cnt_ff == 8'(LOCK_DLY));
endmodule // wdpll_sys_model

// File: verification/wdpll_ctrl_tb_top.sv
// testbench for the watchdog and divider control block
module wdpll_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK  = 20;   // shortened watchdog second
  localparam int LIMIT = 5000; // hang limit in cycles
  logic       clk, rst_n, wr, rd, halt_n, pd_n, ss_c, ss_a, pin, pin_out, pin_oe;
  logic       srst_n, pdwn, lock, clk_en, prog, skew, pt, pc, sse, ssc, ssa, frc, sdir;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] straps, fs;
  logic [5:0] fre, busc, rf;
  logic [2:0] l66, lnk;
  logic [6:0] fb;
  int         failures, checks_done, cyc;
  int         n [9]; // per-window tallies of watched signals
  always #5 clk = ~clk;
  wdpll_ctrl #(.WD_TICK_CYC(TICK), .RST_PULSE_CYC(16), .TEST_PULSE_CYC(1)) dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_shared_pin_in(pin),
    .o_shared_pin_out(pin_out), .o_shared_pin_oe(pin_oe), .o_system_reset_out_n(srst_n),
    .o_power_down(pdwn), .i_frequency_strap_select(straps), .i_pll_lock(lock),
    .i_ss_center(ss_c), .i_ss_amount_hi(ss_a), .i_bus_clock_halt_n(halt_n),
    .i_free_run_en(fre), .i_link_66_sel(l66), .o_strap_fs(fs), .o_clk_out_en(clk_en),
    .o_feedback_divider_value(fb), .o_reference_divider_value(rf),
    .o_use_prog_div(prog), .o_cpu_skew(skew), .o_cpu_pulse_t(pt), .o_cpu_pulse_c(pc),
    .o_ss_enable(sse), .o_ss_center(ssc), .o_ss_amount_hi(ssa), .o_ss_dir(sdir),
    .o_bus_clock_outputs(busc), .o_free_running_bus_clock(frc), .o_bus_or_link_clock(lnk));
  wdpll_sys_model #(.LOCK_DLY(20)) sys_u (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pd_n(pd_n), .o_pin(pin), .o_lock(lock));
  // one compare for every byte-sized result
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // byte write strobe, launched and dropped on falling edges
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // read data is settled one cycle after the strobe edge
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, e);
  endtask
  // tally pulse, reset and clock activity over a window
  task watch(input int c);
    n = '{default:0};
    repeat (c)
    begin
      @(negedge clk);
      n[0] += (pt === 1'b1);
      n[1] += (srst_n === 1'b0);
      n[2] += (busc[0] === 1'b1);
      n[3] += (busc[5] === 1'b1);
      n[4] += (frc === 1'b1);
      n[5] += (lnk[0] === 1'b1);
      n[6] += (pc === 1'b0);
      n[7] += (pin === 1'b0);
      n[8] += (sdir === 1'b1);
    end
  endtask
  task complete_run;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard: counts as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      failures++;
      complete_run;
    end
  end
  initial
  begin
    {clk, rst_n, wr, rd, addr, wdata, fre, l66, ss_a, cyc, failures, checks_done} = '0;
    {pd_n, ss_c, halt_n} = 3'b111;
    straps = 4'h6;
    repeat (6) @(negedge clk);
    chk({7'h00, clk_en}, 8'h00);
    rst_n = 1'b1;
    watch(6);
    chk({4'h0, fs}, 8'h06);
    chk(8'(n[2] + n[4] + n[5]), 8'h00);
    watch(30);
    chk({5'h00, sse, ssc, ssa}, 8'h06);
    for (int a = 7; a < 11; a++)
      rd_chk(8'(a), 8'h00);
    reg_wr(8'h0A, 8'hFF); // unmapped write is dropped
    rd_chk(8'h0A, 8'h00);
    reg_wr(8'h08, 8'h28);
    reg_wr(8'h09, 8'hBD);
    watch(2);
    chk({1'b0, fb}, 8'h28);
    chk({2'b00, rf}, 8'h1E);
    chk({6'h00, skew, prog}, 8'h03);
    reg_wr(8'h08, 8'h32);
    reg_wr(8'h09, 8'h51);
    rd_chk(8'h09, 8'h51);
    reg_wr(8'h08, 8'hB2);
    watch(8);
    chk(8'(n[0]), 8'h01);
    chk(8'(n[6]), 8'h01);
    reg_wr(8'h08, 8'hB2); // bit already high, so no edge
    watch(8);
    chk(8'(n[0]), 8'h00);
    reg_wr(8'h08, 8'h32);
    // expiry with the pin as reset output, both revert choices
    for (int r = 1; r >= 0; r--)
    begin
      reg_wr(8'h07, r ? 8'h41 : 8'h01);
      watch(TICK / 2);
      chk(8'(n[1]), 8'h00);
      watch(TICK + 20);
      chk(8'(n[1]), 8'h10);
      chk(8'(n[7]), 8'h10);
      rd_chk(8'h07, r ? 8'h51 : 8'h11);
      rd_chk(8'h08, 8'h28);
      rd_chk(8'h09, r ? 8'h3D : 8'h3C);
      reg_wr(8'h07, 8'h00);
      rd_chk(8'h07, 8'h00);
    end
    chk({7'h00, prog}, 8'h00);
    // pin as power-down input: expiry must not pulse reset
    reg_wr(8'h07, 8'h81);
    pd_n = 1'b0;
    watch(TICK + 20);
    chk({6'h00, pin_oe, pdwn}, 8'h01);
    chk(8'(n[1]), 8'h00);
    pd_n = 1'b1;
    watch(4);
    chk({7'h00, pdwn}, 8'h00);
    rd_chk(8'h07, 8'h91);
    reg_wr(8'h07, 8'h00);
    watch(1);
    chk({7'h00, pin_oe}, 8'h01);
    // bus clock halt, then free-running and fast link exceptions
    halt_n = 1'b0;
    watch(10);
    watch(9);
    chk(8'(n[2] + n[3] + n[5]), 8'h00);
    chk(8'(n[4]), 8'h03);
    fre = 6'h01;
    l66 = 3'h7;
    watch(10);
    watch(9);
    chk(8'(n[2]), 8'h03);
    chk(8'(n[3]), 8'h00);
    chk(8'(n[5]), 8'h03);
    halt_n = 1'b1;
    watch(10);
    watch(9);
    chk(8'(n[3]), 8'h03);
    // 33 kHz ramp: any full period of 3030 cycles is high for exactly 1515
    watch(3030);
    chk(8'(n[8]), 8'hEB);
    chk(8'(n[8] >> 8), 8'h05);
    complete_run;
  end
endmodule // wdpll_ctrl_tb_top
